// [shared/txi_pkg.sv]
// package: register map, field positions and carriers of the transmit-mode event block
package txi_pkg;

    // ********************************************************************
    // register map (byte addresses)
    // ********************************************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  ADDR_CLEAR      = 8'h28;
    localparam logic [7:0]  ADDR_STATUS     = 8'h2c;
    localparam logic [7:0]  ADDR_FLAGS      = 8'h30;
    localparam logic [7:0]  ADDR_ENABLE     = 8'h34;

    // ********************************************************************
    // field positions shared by all four registers
    // ********************************************************************
    localparam int          BIT_ADAPTOR     = 18;
    localparam int          BIT_AUTH_PASS   = 17;
    localparam int          BIT_AUTH_PKT    = 16;
    localparam int          BIT_CSP_PKT     = 15;
    localparam int          BIT_EPT_RESTART = 14;
    localparam int          BIT_PROP_PKT    = 13;
    localparam int          BIT_BLE_ADDR    = 8;
    localparam int          BIT_INIT_DONE   = 7;
    localparam int          BIT_CONFLICT    = 6;
    localparam int          BIT_MODE_CHANGE = 5;
    localparam int          BIT_CONFIG_PKT  = 4;
    localparam int          BIT_IDENT_PKT   = 3;
    localparam int          BIT_SIG_PKT     = 2;
    localparam int          BIT_PING        = 1;
    localparam int          BIT_EPT_ERROR   = 0;

    // ********************************************************************
    // reset values and masks
    // ********************************************************************
    localparam logic [31:0] DEFINED_MASK    = 32'h0007e1ff;
    localparam logic [31:0] FLAGS_RESET     = 32'h00000000;
    localparam logic [31:0] STATUS_RESET    = 32'h00000000;
    localparam logic [31:0] ENABLE_RESET    = 32'h0007e1ff;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ********************************************************************
    // carriers
    // ********************************************************************
    // one bit per condition, most significant first
    typedef struct packed {
        logic adaptor_done;
        logic auth_pass;
        logic auth_pkt;
        logic csp_pkt;
        logic ept_restart;
        logic prop_pkt;
        logic ble_addr;
        logic init_done;
        logic conflict;
        logic mode_change;
        logic config_pkt;
        logic ident_pkt;
        logic sig_pkt;
        logic ping_started;
        logic ept_error;
    } txi_evt_s;

    // whole state of the block
    typedef struct packed {
        logic [31:0]       status;
        logic [31:0]       flags;
        logic [31:0]       enable;
        logic              irq;
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } txi_state_s;

endpackage : txi_pkg

// [src/txi_event_regs.sv]
// module: transmit-mode live status, latched interrupt flags and AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
// Contract
// - set bit 18 when power-adaptor detection completes (needs external circuitry)
// - set bit 17 once remote receiver identity authentication passes
// - set bit 16 when an identity-authentication packet arrives
// - set bit 15 on CSP packet; live bit clears together with its flag
// - set bit 14 when an end-of-transfer asking for restart arrives
// - set bit 13 when a proprietary packet arrives
// - set bit 8 when a BLE address arrives
// - set bit 7 after transmit-mode initialization succeeds
// - set bit 6 when transmitting while placed on another transmitter
// - set bit 5 whenever the operating mode changes
// - set bit 4 when a configuration packet arrives
// - set bit 3 when an identification packet arrives
// - set bit 2 when a signal strength packet arrives
// - set bit 1 when a digital ping starts
// - set bit 0 on end-of-transfer error; host should remove power
// - live status is read-only at 0x2c, valid in transmit mode
// - latched flags read-only at 0x30, reset to zero
// - writing one at 0x28 clears the flag; clear bit self-returns to zero
// - enable register at 0x34 gates each interrupt, all ones after reset
module txi_event_regs (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      tx_mode_active,
    input  wire txi_pkg::txi_evt_s         evt_pulse,
    input  wire txi_pkg::txi_evt_s         cond_level,
    output logic                           host_irq,
    input  wire logic [txi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [txi_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    // ********************************************************************
    // helper functions
    // ********************************************************************
    // spread a condition struct onto its register bit positions
    function automatic logic [31:0] place(input txi_pkg::txi_evt_s e);
        logic [31:0] v;
        v = 32'h00000000;
        v[txi_pkg::BIT_ADAPTOR]     = e.adaptor_done;
        v[txi_pkg::BIT_AUTH_PASS]   = e.auth_pass;
        v[txi_pkg::BIT_AUTH_PKT]    = e.auth_pkt;
        v[txi_pkg::BIT_CSP_PKT]     = e.csp_pkt;
        v[txi_pkg::BIT_EPT_RESTART] = e.ept_restart;
        v[txi_pkg::BIT_PROP_PKT]    = e.prop_pkt;
        v[txi_pkg::BIT_BLE_ADDR]    = e.ble_addr;
        v[txi_pkg::BIT_INIT_DONE]   = e.init_done;
        v[txi_pkg::BIT_CONFLICT]    = e.conflict;
        v[txi_pkg::BIT_MODE_CHANGE] = e.mode_change;
        v[txi_pkg::BIT_CONFIG_PKT]  = e.config_pkt;
        v[txi_pkg::BIT_IDENT_PKT]   = e.ident_pkt;
        v[txi_pkg::BIT_SIG_PKT]     = e.sig_pkt;
        v[txi_pkg::BIT_PING]        = e.ping_started;
        v[txi_pkg::BIT_EPT_ERROR]   = e.ept_error;
        return v;
    endfunction : place

    // byte strobes widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    // word address of a byte address, low two bits forced to zero
    function automatic logic [txi_pkg::ADDR_W-1:0] word_of(
        input logic [txi_pkg::ADDR_W-1:0] a);
        return {a[txi_pkg::ADDR_W-1:2], 2'h0};
    endfunction : word_of

    // ********************************************************************
    // state and combinational next value
    // ********************************************************************
    txi_pkg::txi_state_s st;
    txi_pkg::txi_state_s next_st;

    logic [31:0] set_vec;
    logic [31:0] level_vec;
    logic [31:0] clr_vec;
    logic        have_aw;
    logic        have_w;
    logic [txi_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [txi_pkg::ADDR_W-1:0] rd_addr;

    // event, bus and register next-state logic
    always_comb begin
        next_st   = st;
        set_vec   = place(evt_pulse);
        level_vec = place(cond_level);
        clr_vec   = 32'h00000000;

        // write channel capture, either order
        have_aw = st.aw_got | (s_axi_awvalid & st.awready);
        have_w  = st.w_got | (s_axi_wvalid & st.wready);
        wr_addr = st.aw_got ? st.awaddr : s_axi_awaddr;
        wr_data = st.w_got ? st.wdata : s_axi_wdata;
        wr_strb = st.w_got ? st.wstrb : s_axi_wstrb;
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // perform write once address and data are both held
        if (have_aw && have_w && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = txi_pkg::RESP_OKAY;
            case (word_of(wr_addr))
                txi_pkg::ADDR_CLEAR: begin
                    clr_vec = wr_data & strb_mask(wr_strb) & txi_pkg::DEFINED_MASK;
                end
                txi_pkg::ADDR_ENABLE: begin
                    next_st.enable = ((st.enable & ~strb_mask(wr_strb))
                                   | (wr_data & strb_mask(wr_strb)))
                                   & txi_pkg::DEFINED_MASK;
                end
                txi_pkg::ADDR_STATUS,
                txi_pkg::ADDR_FLAGS: begin
                    next_st.bresp = txi_pkg::RESP_OKAY; // read-only, write dropped
                end
                default: begin
                    next_st.bresp = txi_pkg::RESP_SLVERR;
                end
            endcase
        end

        next_st.flags = ((st.flags & ~clr_vec) | set_vec) & txi_pkg::DEFINED_MASK;

        next_st.status = tx_mode_active ? (level_vec & txi_pkg::DEFINED_MASK)
                                        : txi_pkg::STATUS_RESET;
        // csp bit sticky, cleared with flag
        next_st.status[txi_pkg::BIT_CSP_PKT] =
            (st.status[txi_pkg::BIT_CSP_PKT] & ~clr_vec[txi_pkg::BIT_CSP_PKT])
            | set_vec[txi_pkg::BIT_CSP_PKT];

        next_st.irq = |(next_st.flags & next_st.enable);

        // read channel
        rd_addr = word_of(s_axi_araddr);
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = txi_pkg::RESP_OKAY;
            case (rd_addr)
                txi_pkg::ADDR_CLEAR:  next_st.rdata = 32'h00000000;
                txi_pkg::ADDR_STATUS: next_st.rdata = st.status & txi_pkg::DEFINED_MASK;
                txi_pkg::ADDR_FLAGS:  next_st.rdata = st.flags & txi_pkg::DEFINED_MASK;
                txi_pkg::ADDR_ENABLE: next_st.rdata = st.enable & txi_pkg::DEFINED_MASK;
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = txi_pkg::RESP_SLVERR;
                end
            endcase
        end

        // ready flags follow what is still open
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    // synchronous reset to defined values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.status  <= txi_pkg::STATUS_RESET;
            st.flags   <= txi_pkg::FLAGS_RESET;
            st.enable  <= txi_pkg::ENABLE_RESET;
            st.bresp   <= txi_pkg::RESP_OKAY;
            st.rresp   <= txi_pkg::RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign host_irq      = st.irq;
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = st.rdata;

    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic past_rst;
    always_ff @(posedge aclk) begin
        past_rst <= !aresetn;
    end

    AST_ADAPTOR_LATCH: assert property (
        evt_pulse.adaptor_done |=> st.flags[txi_pkg::BIT_ADAPTOR])
        else $error("adaptor flag not latched");

    AST_PING_LATCH: assert property (
        evt_pulse.ping_started |=> st.flags[txi_pkg::BIT_PING] [*1])
        else $error("ping flag not latched");

    AST_EPT_IRQ: assert property (
        evt_pulse.ept_error && st.enable[txi_pkg::BIT_EPT_ERROR] |=> host_irq)
        else $error("error event gave no request");

    AST_CSP_STICKY: assert property (
        evt_pulse.csp_pkt
        || (st.status[txi_pkg::BIT_CSP_PKT] && !clr_vec[txi_pkg::BIT_CSP_PKT])
        |=> st.status[txi_pkg::BIT_CSP_PKT])
        else $error("csp status dropped without clear");

    AST_CSP_CLEAR_TOGETHER: assert property (
        $fell(st.status[txi_pkg::BIT_CSP_PKT]) |-> $fell(st.flags[txi_pkg::BIT_CSP_PKT]))
        else $error("csp status cleared apart from its flag");

    AST_STATUS_GATED: assert property (
        !tx_mode_active |=> (st.status & ~(32'h1 << txi_pkg::BIT_CSP_PKT)) == 32'h0)
        else $error("live status outside transmit mode");

    AST_RESERVED_ZERO: assert property (
        s_axi_rvalid |-> (s_axi_rdata & ~txi_pkg::DEFINED_MASK) == 32'h0)
        else $error("reserved bits read nonzero");

    AST_FLAG_HOLD: assert property (
        st.flags[txi_pkg::BIT_AUTH_PASS] && !st.bvalid ##1 !st.bvalid
        |-> st.flags[txi_pkg::BIT_AUTH_PASS])
        else $error("flag dropped without clear");

    AST_ENABLE_DEFAULT: assert property (
        past_rst && !st.bvalid |-> st.enable == txi_pkg::ENABLE_RESET)
        else $error("enable not all ones after reset");

    AST_IRQ_MATCH: assert property (
        host_irq == |(st.flags & st.enable))
        else $error("request does not match enabled flags");

    AST_WRITE_RESP: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write response late");

    COV_CLEAR_WRITE: cover property (
        st.bvalid && st.flags == 32'h0 ##1 st.irq == 1'b0);
    COV_IRQ_RISE: cover property ($rose(host_irq));
    COV_SET_CLEAR_SAME: cover property (
        evt_pulse.csp_pkt && have_aw && have_w && !st.bvalid);
    COV_READ_FLAGS: cover property (
        s_axi_arvalid && s_axi_arready && word_of(s_axi_araddr) == txi_pkg::ADDR_FLAGS);

endmodule : txi_event_regs

// [verification/txi_event_regs_test.sv]
// testbench: event rows, register access, gating and reset cases of the event block
`timescale 1ns/1ns
module txi_event_regs_test;
    typedef struct packed { txi_pkg::txi_evt_s evt; logic [31:0] word; } txi_row_s;
    logic                       aclk;
    logic                       aresetn;
    logic                       tx_mode;
    txi_pkg::txi_evt_s          evt_pulse;
    txi_pkg::txi_evt_s          cond_level;
    logic                       irq;
    logic [7:0]                 awaddr, araddr;
    logic [31:0]                wdata, rdata;
    logic [3:0]                 wstrb;
    logic [1:0]                 bresp, rresp;
    logic                       awvalid, awready, wvalid, wready, bvalid, bready;
    logic                       arvalid, arready, rvalid, rready;
    int                         n_fail = 0;
    int                         n_compared = 0;
    // one condition per row: event bit in, register word out
    txi_row_s rows [15] = '{'{15'h4000, 32'h00040000}, '{15'h2000, 32'h00020000},
        '{15'h1000, 32'h00010000}, '{15'h0800, 32'h00008000}, '{15'h0400, 32'h00004000},
        '{15'h0200, 32'h00002000}, '{15'h0100, 32'h00000100}, '{15'h0080, 32'h00000080},
        '{15'h0040, 32'h00000040}, '{15'h0020, 32'h00000020}, '{15'h0010, 32'h00000010},
        '{15'h0008, 32'h00000008}, '{15'h0004, 32'h00000004}, '{15'h0002, 32'h00000002},
        '{15'h0001, 32'h00000001}};

    txi_event_regs i_txi_event_regs (.aclk(aclk), .aresetn(aresetn), .tx_mode_active(tx_mode),
        .evt_pulse(evt_pulse), .cond_level(cond_level), .host_irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    txi_host_model i_txi_host_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ********************************************************************
    // checking and bus helpers
    // ********************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // a response that never came leaves x behind and ends the run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic [1:0] r;
        i_txi_host_model.write(a, d, s, r);
        check("bresp", 32'(r), 32'(er));
        if ($isunknown(r)) final_report();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        i_txi_host_model.read(a, d, r);
        check("rresp", 32'(r), 32'(er));
        check("rdata", d, exp);
        if ($isunknown(r)) final_report();
    endtask : rd

    task automatic pulse(input txi_pkg::txi_evt_s e);
        evt_pulse <= e;
        @(posedge aclk);
        evt_pulse <= '0;
        @(posedge aclk);
    endtask : pulse

    // ********************************************************************
    // main sequence
    // ********************************************************************
    initial begin
        aresetn = 1'b0;
        tx_mode = 1'b1;
        evt_pulse = '0;
        cond_level = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(txi_pkg::ADDR_FLAGS, 32'h0, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_ENABLE, 32'h0007e1ff, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_STATUS, 32'h0, txi_pkg::RESP_OKAY);
        check("irq", 32'(irq), 32'h0);
        // each condition: set, latch, interrupt, clear with its live bit
        foreach (rows[k]) begin
            cond_level <= rows[k].evt;
            pulse(rows[k].evt);
            check("irq", 32'(irq), 32'h1);
            rd(txi_pkg::ADDR_FLAGS, rows[k].word, txi_pkg::RESP_OKAY);
            rd(txi_pkg::ADDR_STATUS, rows[k].word, txi_pkg::RESP_OKAY);
            cond_level <= '0;
            wr(txi_pkg::ADDR_CLEAR, rows[k].word, 4'hf, txi_pkg::RESP_OKAY);
            check("irq", 32'(irq), 32'h0);
            rd(txi_pkg::ADDR_FLAGS, 32'h0, txi_pkg::RESP_OKAY);
            rd(txi_pkg::ADDR_STATUS, 32'h0, txi_pkg::RESP_OKAY);
        end
        // back-to-back events both latch; clear one leaves the other
        evt_pulse <= 15'h0002;
        @(posedge aclk);
        pulse(15'h0008);
        rd(txi_pkg::ADDR_FLAGS, 32'h0000000a, txi_pkg::RESP_OKAY);
        wr(txi_pkg::ADDR_CLEAR, 32'hfff81e02, 4'hf, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_FLAGS, 32'h00000008, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_CLEAR, 32'h0, txi_pkg::RESP_OKAY);
        wr(txi_pkg::ADDR_CLEAR, 32'h8, 4'hf, txi_pkg::RESP_OKAY);
        // csp event in the very cycle that its clear is taken: the set wins
        fork
            wr(txi_pkg::ADDR_CLEAR, 32'h00008000, 4'hf, txi_pkg::RESP_OKAY);
            begin
                evt_pulse.csp_pkt <= 1'b1;
                @(posedge aclk);
                evt_pulse <= '0;
            end
        join
        rd(txi_pkg::ADDR_FLAGS, 32'h00008000, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_STATUS, 32'h00008000, txi_pkg::RESP_OKAY);
        wr(txi_pkg::ADDR_CLEAR, 32'h00008000, 4'hf, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_STATUS, 32'h0, txi_pkg::RESP_OKAY);
        // reserved enable bits ignored, byte lane honoured, gating of the request
        wr(txi_pkg::ADDR_ENABLE, 32'hffffffff, 4'hf, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_ENABLE, 32'h0007e1ff, txi_pkg::RESP_OKAY);
        wr(txi_pkg::ADDR_ENABLE, 32'h0, 4'h1, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_ENABLE, 32'h0007e100, txi_pkg::RESP_OKAY);
        pulse(15'h0001);
        check("irq", 32'(irq), 32'h0);
        rd(txi_pkg::ADDR_FLAGS, 32'h1, txi_pkg::RESP_OKAY);
        wr(txi_pkg::ADDR_ENABLE, 32'h1, 4'h1, txi_pkg::RESP_OKAY);
        check("irq", 32'(irq), 32'h1);
        // read-only and unmapped places, slow host, live status outside transmit mode
        i_txi_host_model.ready_delay = 3;
        wr(txi_pkg::ADDR_FLAGS, 32'h0, 4'hf, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_FLAGS, 32'h1, txi_pkg::RESP_OKAY);
        wr(txi_pkg::ADDR_STATUS, 32'hffffffff, 4'hf, txi_pkg::RESP_OKAY);
        wr(8'h40, 32'hffffffff, 4'hf, txi_pkg::RESP_SLVERR);
        rd(8'h40, 32'h0, txi_pkg::RESP_SLVERR);
        tx_mode <= 1'b0;
        cond_level <= 15'h7fff;
        // let the gated levels reach the status flops before reading
        repeat (2) @(posedge aclk);
        rd(txi_pkg::ADDR_STATUS, 32'h0, txi_pkg::RESP_OKAY);
        tx_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        // bit 15 follows csp events only, not the level
        rd(txi_pkg::ADDR_STATUS, 32'h000761ff, txi_pkg::RESP_OKAY);
        i_txi_host_model.ready_delay = 0;
        cond_level <= '0;
        // reset in mid-run returns flags, enables and request to their reset state
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check("irq", 32'(irq), 32'h0);
        rd(txi_pkg::ADDR_FLAGS, 32'h0, txi_pkg::RESP_OKAY);
        rd(txi_pkg::ADDR_ENABLE, 32'h0007e1ff, txi_pkg::RESP_OKAY);
        final_report();
    end

    // overall limit against a hang
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        final_report();
    end
endmodule : txi_event_regs_test

// [verification/txi_host_model.sv]
// host model: AXI4-Lite master that reads, clears and enables the event flags
`timescale 1ns/1ns
module txi_host_model (
    input  wire logic                       aclk,
    output logic [txi_pkg::ADDR_W-1:0]      awaddr,
    output logic                            awvalid,
    input  wire logic                       awready,
    output logic [31:0]                     wdata,
    output logic [3:0]                      wstrb,
    output logic                            wvalid,
    input  wire logic                       wready,
    input  wire logic [1:0]                 bresp,
    input  wire logic                       bvalid,
    output logic                            bready,
    output logic [txi_pkg::ADDR_W-1:0]      araddr,
    output logic                            arvalid,
    input  wire logic                       arready,
    input  wire logic [31:0]                rdata,
    input  wire logic [1:0]                 rresp,
    input  wire logic                       rvalid,
    output logic                            rready
);
    // cycles before a ready is raised, so the slave's answer has to wait
    int ready_delay = 0;

    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // write one word: address and data offered together, each dropped when taken
    task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] resp);
        resp = 2'bxx;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a; // released lines do not keep the old value
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bready && bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (i >= ready_delay) bready <= 1'b1;
        end
    endtask : write

    // read one word, rready held until the answer is seen
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        d = 'x;
        resp = 2'bxx;
        araddr <= a;
        arvalid <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rready && rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            if (i >= ready_delay) rready <= 1'b1;
        end
    endtask : read
endmodule : txi_host_model
